//--- hw/csd_pkg.sv
package csd_pkg;
    // test mode select codes
    localparam logic [1:0] TMODE_SCAN     = 2'h0;
    localparam logic [1:0] TMODE_RSVD_A   = 2'h1;
    localparam logic [1:0] TMODE_RSVD_B   = 2'h2;
    localparam logic [1:0] TMODE_EMUL     = 2'h3;
    localparam logic [1:0] TMODE_RESET    = 2'h3;
    // boot select codes
    localparam logic [1:0] BOOT_EMUL      = 2'h0;
    localparam logic [1:0] BOOT_ROM8      = 2'h1;
    localparam logic [1:0] BOOT_ROM16     = 2'h2;
    localparam logic [1:0] BOOT_RSVD      = 2'h3;
    localparam logic [1:0] BOOT_RESET     = 2'h1;
    // endian select values
    localparam logic       ENDIAN_BIG     = 1'h0;
    localparam logic       ENDIAN_LITTLE  = 1'h1;
    localparam logic       ENDIAN_RESET   = 1'h1;
    // rom bus widths in bits
    localparam logic [4:0] ROM_WIDTH_8    = 5'h08;
    localparam logic [4:0] ROM_WIDTH_16   = 5'h10;
    // synchroniser depth
    localparam int         SYNC_STAGES    = 2;
    // strap vector field positions
    localparam int         STRAP_W        = 6;
    localparam int         POS_TMODE_LO   = 0;
    localparam int         POS_TMODE_HI   = 1;
    localparam int         POS_BOOT_LO    = 2;
    localparam int         POS_BOOT_HI    = 3;
    localparam int         POS_ENDIAN     = 4;
    localparam int         POS_FIX        = 5;
    // strap vector reset value
    localparam logic [5:0] STRAP_RESET    = 6'h37;
endpackage

//--- hw/csd_strap_if.sv
`timescale 1ns/10ps
// synchronised strap vector between synchroniser and decoder
interface csd_strap_if;
    logic [csd_pkg::STRAP_W-1:0] straps;
    modport src (output straps);
    modport dst (input  straps);
endinterface

//--- hw/csd_sync.sv
`timescale 1ns/10ps
module csd_sync #(
    parameter int STAGES = csd_pkg::SYNC_STAGES
) (
    // clock and reset
    input  wire logic                        clock_in,
    input  wire logic                        sys_rst_in,
    // raw pins
    input  wire logic [csd_pkg::STRAP_W-1:0] raw_in,
    // synchronised output
    csd_strap_if.src                         sync_out
);
    logic [csd_pkg::STRAP_W-1:0] stage_q [STAGES];

    // a single flop would let metastable values reach the decode
    if (STAGES < 2) begin
        $error("csd_sync needs at least two stages");
    end

    // synchroniser chain, first stage feeds only the second
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_q[i] <= csd_pkg::STRAP_RESET;
            end
        end else begin
            stage_q[0] <= raw_in;
            for (int i = 1; i < STAGES; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign sync_out.straps = stage_q[STAGES-1];
endmodule

//--- hw/csd_top.sv
`timescale 1ns/10ps
// Operation
// - test code 11 gives emulation, default
// - test code 00 boundary scan; 01/10 reserved
// - functional operation in scan or emulation
// - boot 01 rom 8-bit; 00 emulation
// - boot 10 rom 16-bit on space one
// - endian strap 0 selects big endian
// - endian strap 1 selects little endian
module csd_top (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    // strap pins
    input  wire logic       test_mode_sel_hi_in,
    input  wire logic       test_mode_sel_lo_in,
    input  wire logic       boot_sel_hi_in,
    input  wire logic       boot_sel_lo_in,
    input  wire logic       endian_sel_in,
    input  wire logic       ext_bus_big_endian_fix_in,
    // test mode decode
    output logic [1:0]      test_mode_out,
    output logic            boundary_scan_out,
    output logic            emulation_out,
    output logic            functional_out,
    output logic            test_mode_rsvd_out,
    // boot decode
    output logic [1:0]      boot_mode_out,
    output logic            boot_emul_out,
    output logic            boot_rom_out,
    output logic [4:0]      boot_rom_width_out,
    output logic            boot_rsvd_out,
    // endian decode
    output logic            big_endian_out,
    output logic            endian_fix_err_out,
    // capture status
    output logic            config_valid_out
);
    // synchronised strap vector from the pin synchroniser
    csd_strap_if sync_if ();

    // capture control
    logic                        cap_pend_q;
    logic                        valid_q;
    logic [3:0]                  fill_q;
    logic                        sync_fill_done;
    logic                        cap_fire;
    // held strap vector and the pin vector feeding the chain
    logic [csd_pkg::STRAP_W-1:0] cap_q;
    logic [csd_pkg::STRAP_W-1:0] raw_vec;
    // fields of the held vector
    logic [1:0]                  tmode;
    logic [1:0]                  bmode;
    logic                        endian;
    logic                        fix;
    // decoded values ahead of the output flops
    logic                        tmode_scan;
    logic                        tmode_emul;
    logic                        tmode_rsvd;
    logic                        tmode_func;
    logic                        boot_emul;
    logic                        boot_rom;
    logic                        boot_rsvd;
    logic [4:0]                  boot_width;
    logic                        endian_big;
    logic                        fix_err;

    // fill counter is four bits wide; the chain needs two flops
    if (csd_pkg::SYNC_STAGES < 2 || csd_pkg::SYNC_STAGES > 15) begin
        $error("csd_top needs a synchroniser depth of 2 to 15");
    end

    // gather pins into one vector
    assign raw_vec[csd_pkg::POS_TMODE_LO] = test_mode_sel_lo_in;
    assign raw_vec[csd_pkg::POS_TMODE_HI] = test_mode_sel_hi_in;
    assign raw_vec[csd_pkg::POS_BOOT_LO]  = boot_sel_lo_in;
    assign raw_vec[csd_pkg::POS_BOOT_HI]  = boot_sel_hi_in;
    assign raw_vec[csd_pkg::POS_ENDIAN]   = endian_sel_in;
    assign raw_vec[csd_pkg::POS_FIX]      = ext_bus_big_endian_fix_in;

    csd_sync #(
        .STAGES (csd_pkg::SYNC_STAGES)
    ) u_sync (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .raw_in     (raw_vec),
        .sync_out   (sync_if)
    );

    // boot width lookup
    function automatic logic [4:0] rom_width(input logic [1:0] code);
        case (code)
            csd_pkg::BOOT_ROM8:  rom_width = csd_pkg::ROM_WIDTH_8;
            csd_pkg::BOOT_ROM16: rom_width = csd_pkg::ROM_WIDTH_16;
            default:             rom_width = 5'h00;
        endcase
    endfunction

    // test codes that leave the device in functional operation
    function automatic logic tmode_is_func(input logic [1:0] code);
        tmode_is_func = (code == csd_pkg::TMODE_SCAN) || (code == csd_pkg::TMODE_EMUL);
    endfunction

    // reserved test codes, flagged only
    function automatic logic tmode_is_rsvd(input logic [1:0] code);
        tmode_is_rsvd = (code == csd_pkg::TMODE_RSVD_A) || (code == csd_pkg::TMODE_RSVD_B);
    endfunction

    // both rom boot codes
    function automatic logic boot_is_rom(input logic [1:0] code);
        boot_is_rom = (code == csd_pkg::BOOT_ROM8) || (code == csd_pkg::BOOT_ROM16);
    endfunction

    // fill counter covering the synchroniser depth after release
    // pins seen before release never reach the capture register
    assign sync_fill_done = (fill_q == 4'(csd_pkg::SYNC_STAGES));

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            fill_q <= 4'h0;
        end else if (!sync_fill_done) begin
            fill_q <= fill_q + 4'h1;
        end
    end

    // capture after release, on the edge after the fill count is reached
    // one capture per reset, once the chain holds post-release pins
    assign cap_fire = cap_pend_q && sync_fill_done;

    // capture handshake state
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cap_pend_q <= 1'b1;
            valid_q    <= 1'b0;
        end else if (cap_fire) begin
            cap_pend_q <= 1'b0;
            valid_q    <= 1'b1;
        end
    end

    // held strap vector
    // later pin changes are ignored until the next reset
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cap_q <= csd_pkg::STRAP_RESET;
        end else if (cap_fire) begin
            cap_q <= sync_if.straps;
        end
    end

    // field extraction from held straps; hi pin is the code msb
    assign tmode  = {cap_q[csd_pkg::POS_TMODE_HI], cap_q[csd_pkg::POS_TMODE_LO]};
    assign bmode  = {cap_q[csd_pkg::POS_BOOT_HI], cap_q[csd_pkg::POS_BOOT_LO]};
    assign endian = cap_q[csd_pkg::POS_ENDIAN];
    assign fix    = cap_q[csd_pkg::POS_FIX];

    assign tmode_emul = (tmode == csd_pkg::TMODE_EMUL);

    assign tmode_scan = (tmode == csd_pkg::TMODE_SCAN);
    assign tmode_rsvd = tmode_is_rsvd(tmode);

    // functional in both modes
    // held low until the capture has completed
    assign tmode_func = valid_q && tmode_is_func(tmode);

    assign boot_emul  = (bmode == csd_pkg::BOOT_EMUL);

    assign boot_rom   = boot_is_rom(bmode);
    assign boot_width = rom_width(bmode);

    assign boot_rsvd  = (bmode == csd_pkg::BOOT_RSVD);

    assign endian_big = (endian == csd_pkg::ENDIAN_BIG);

    // correctness strap check
    // flags a board that leaves the strap high in big endian
    assign fix_err    = endian_big && fix;

    // registered test mode outputs
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            test_mode_out      <= csd_pkg::TMODE_RESET;
            boundary_scan_out  <= 1'b0;
            emulation_out      <= 1'b1;
            functional_out     <= 1'b0;
            test_mode_rsvd_out <= 1'b0;
        end else begin
            test_mode_out      <= tmode;
            boundary_scan_out  <= tmode_scan;
            emulation_out      <= tmode_emul;
            functional_out     <= tmode_func;
            test_mode_rsvd_out <= tmode_rsvd;
        end
    end

    // registered boot outputs
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            boot_mode_out      <= csd_pkg::BOOT_RESET;
            boot_emul_out      <= 1'b0;
            boot_rom_out       <= 1'b1;
            boot_rom_width_out <= csd_pkg::ROM_WIDTH_8;
            boot_rsvd_out      <= 1'b0;
        end else begin
            boot_mode_out      <= bmode;
            boot_emul_out      <= boot_emul;
            boot_rom_out       <= boot_rom;
            boot_rom_width_out <= boot_width;
            boot_rsvd_out      <= boot_rsvd;
        end
    end

    // registered endian outputs, little endian out of reset
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            big_endian_out     <= 1'b0;
            endian_fix_err_out <= 1'b0;
        end else begin
            big_endian_out     <= endian_big;
            endian_fix_err_out <= fix_err;
        end
    end

    // capture status, one edge behind the capture
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            config_valid_out <= 1'b0;
        end else begin
            config_valid_out <= valid_q;
        end
    end
endmodule

//--- testbench/csd_board.sv
`timescale 1ns/10ps
module csd_board (
    // requested straps
    input  wire logic [1:0] tmode_in,
    input  wire logic [1:0] boot_in,
    input  wire logic       little_in,
    input  wire logic       fix_in,
    input  wire logic       bad_in,
    // strap pins
    output logic            tmode_hi_out,
    output logic            tmode_lo_out,
    output logic            boot_hi_out,
    output logic            boot_lo_out,
    output logic            endian_out,
    output logic            fix_out
);
    // test mode straps follow the request, all four codes passed through
    assign {tmode_hi_out, tmode_lo_out} = tmode_in;
    // reserved boot code only on command
    assign {boot_hi_out, boot_lo_out} = (boot_in == 2'h3 && !bad_in) ? 2'h1 : boot_in;
    assign endian_out = little_in;
    // fix strap low for big endian unless bad_in is set
    assign fix_out = fix_in & (little_in | bad_in);
endmodule

//--- testbench/csd_props.sv
`timescale 1ns/10ps
module csd_props (
    // clock, reset and pins
    input wire logic       clock_in,
    input wire logic       sys_rst_in,
    input wire logic       endian_sel_in,
    input wire logic       ext_bus_big_endian_fix_in,
    // decoded outputs
    input wire logic [1:0] test_mode_out,
    input wire logic       boundary_scan_out,
    input wire logic       emulation_out,
    input wire logic       functional_out,
    input wire logic       test_mode_rsvd_out,
    input wire logic [1:0] boot_mode_out,
    input wire logic       boot_emul_out,
    input wire logic       boot_rom_out,
    input wire logic [4:0] boot_rom_width_out,
    input wire logic       boot_rsvd_out,
    input wire logic       big_endian_out,
    input wire logic       endian_fix_err_out,
    input wire logic       config_valid_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // four idle sampled edges after release, then valid
    sequence s_fill;
        !config_valid_out [*4];
    endsequence
    chk_valid_walk: assert property ($fell(sys_rst_in) |-> s_fill ##1 config_valid_out)
        else $error("valid timing");
    chk_emul_code: assert property (config_valid_out && test_mode_out == 2'h3 |->
        emulation_out && !boundary_scan_out) else $error("emulation decode");
    chk_scan_code: assert property (config_valid_out && test_mode_out == 2'h0 |->
        boundary_scan_out && !emulation_out) else $error("scan decode");
    chk_rsvd_flag: assert property (test_mode_rsvd_out == ^test_mode_out)
        else $error("reserved flag");
    chk_func_mode: assert property (functional_out == (config_valid_out && !(^test_mode_out)))
        else $error("functional decode");
    chk_rom8_boot: assert property (boot_mode_out == 2'h1 |-> boot_rom_out &&
        boot_rom_width_out == 5'h08) else $error("rom8 decode");
    chk_rom16_boot: assert property (boot_mode_out == 2'h2 |-> boot_rom_out &&
        boot_rom_width_out == 5'h10) else $error("rom16 decode");
    chk_emul_boot: assert property (boot_mode_out == 2'h0 |-> boot_emul_out &&
        !boot_rom_out && boot_rom_width_out == 5'h00) else $error("emulation boot decode");
    chk_boot_rsvd: assert property (boot_rsvd_out == (boot_mode_out == 2'h3))
        else $error("reserved boot flag");
    chk_endian_cap: assert property ($rose(config_valid_out) |->
        big_endian_out == !$past(endian_sel_in, 2)) else $error("endian capture");
    chk_cfg_hold: assert property (config_valid_out && $past(config_valid_out) |->
        $stable(test_mode_out) && $stable(boot_mode_out) && $stable(endian_fix_err_out))
        else $error("capture not held");
endmodule
bind csd_top csd_props u_csd_props (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .endian_sel_in(endian_sel_in), .ext_bus_big_endian_fix_in(ext_bus_big_endian_fix_in),
    .test_mode_out(test_mode_out), .boundary_scan_out(boundary_scan_out),
    .emulation_out(emulation_out), .functional_out(functional_out),
    .test_mode_rsvd_out(test_mode_rsvd_out), .boot_mode_out(boot_mode_out),
    .boot_emul_out(boot_emul_out), .boot_rsvd_out(boot_rsvd_out),
    .boot_rom_out(boot_rom_out), .boot_rom_width_out(boot_rom_width_out),
    .big_endian_out(big_endian_out), .endian_fix_err_out(endian_fix_err_out),
    .config_valid_out(config_valid_out));

//--- testbench/test_config_strap_decoder.sv
`timescale 1ns/10ps
module test_config_strap_decoder;
    logic        clock_in = 0, sys_rst_in = 1, little = 0, fix = 0, bad = 0, chk_now = 0;
    logic        prev_v = 0, th, tl, bh, bl, es, fx;
    logic        sc_o, em_o, fn_o, tr_o, ee_o, ro_o, rs_o, bg_o, er_o, v_o;
    logic [1:0]  tmode = 0, boot = 0, tm_o, bm_o, eb;
    logic [4:0]  w_o;
    logic [17:0] q[$], e;
    int          err_count = 0, compares = 0, n;
    wire  [17:0] act = {tm_o, sc_o, em_o, fn_o, tr_o, bm_o, ee_o, ro_o, w_o, rs_o, bg_o, er_o};
    always #2 clock_in = ~clock_in;
    csd_board u_csd_board (.tmode_in(tmode), .boot_in(boot), .little_in(little), .fix_in(fix),
        .bad_in(bad), .tmode_hi_out(th), .tmode_lo_out(tl), .boot_hi_out(bh),
        .boot_lo_out(bl), .endian_out(es), .fix_out(fx));
    csd_top u_csd_top (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .test_mode_sel_hi_in(th), .test_mode_sel_lo_in(tl), .boot_sel_hi_in(bh),
        .boot_sel_lo_in(bl), .endian_sel_in(es), .ext_bus_big_endian_fix_in(fx),
        .test_mode_out(tm_o), .boundary_scan_out(sc_o), .emulation_out(em_o),
        .functional_out(fn_o), .test_mode_rsvd_out(tr_o), .boot_mode_out(bm_o),
        .boot_emul_out(ee_o), .boot_rom_out(ro_o), .boot_rom_width_out(w_o),
        .boot_rsvd_out(rs_o), .big_endian_out(bg_o), .endian_fix_err_out(er_o),
        .config_valid_out(v_o));
    // expected decode of one strap set
    function automatic logic [17:0] exp_cfg(logic [1:0] t, b, logic l, f, v);
        return {t, t == 2'h0, t == 2'h3, v && !(^t), ^t, b, b == 2'h0, b == 2'h1 || b == 2'h2,
            b == 2'h1 ? csd_pkg::ROM_WIDTH_8 : b == 2'h2 ? csd_pkg::ROM_WIDTH_16 : 5'h00,
            b == 2'h3, !l, !l && f};
    endfunction
    task automatic compare_cfg(input logic [17:0] x, input logic [17:0] a);
        compares++;
        if (a !== x) begin
            err_count++;
            $display("CHECK FAILED %0t decode exp %h got %h", $time, x, a);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // monitor: oldest note against outputs when a result shows
    always @(posedge clock_in) begin
        if (chk_now || (v_o === 1'b1 && prev_v !== 1'b1))
            compare_cfg(q.pop_front(), act);
        prev_v <= v_o;
    end
    // driver: every test and boot code, random endian straps
    initial begin
        void'($urandom(39));
        repeat (5) @(posedge clock_in);
        for (int t = 0; t < 16; t++) begin
            @(posedge clock_in);
            #1 chk_now = 0;
            sys_rst_in = 1;
            tmode = 2'(t);
            boot = 2'(t / 4);
            bad = t >= 12;
            little = 1'($urandom);
            fix = 1'($urandom);
            @(posedge clock_in);
            #1 q.push_back(exp_cfg(2'h3, 2'h1, 1'b1, 1'b0, 1'b0));
            chk_now = 1;
            @(posedge clock_in);
            #1 chk_now = 0;
            sys_rst_in = 0;
            eb = (boot == 2'h3 && !bad) ? 2'h1 : boot;
            e = exp_cfg(tmode, eb, little, fix & (little | bad), 1'b1);
            q.push_back(e);
            for (n = 0; n < 10 && v_o !== 1'b1; n++)
                @(posedge clock_in);
            if (n == 10) begin
                err_count++;
                $display("CHECK FAILED %0t config valid timeout", $time);
                break;
            end
            #1 {tmode, boot, little, fix} = 6'($urandom);
            repeat (3) @(posedge clock_in);
            #1 q.push_back(e);
            chk_now = 1;
            $display("test %0d done", t);
        end
        @(posedge clock_in);
        #1 chk_now = 0;
        @(posedge clock_in);
        finish_test();
    end
endmodule
